// ==== rtl/scs_speed_cmd.sv ====
`timescale 1ns/100ps
module scs_speed_cmd (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// speed select pins
	input wire logic speed_select_bit0,
	input wire logic speed_select_bit1,
	// analog reference and loop feedback
	input wire logic signed [15:0] analog_ref,
	input wire logic signed [15:0] pos_error,
	input wire logic signed [15:0] pos_rate,
	input wire logic signed [16:0] speed_fb,
	// auto tuner gains
	input wire logic auto_gain_valid,
	input wire logic [15:0] auto_kpp,
	input wire logic [15:0] auto_ff,
	input wire logic [15:0] auto_spkp,
	input wire logic [15:0] auto_spki,
	// parameter port
	input wire logic param_wr,
	input wire logic param_rd,
	input wire logic [15:0] param_addr,
	input wire logic [31:0] param_wdata,
	output logic [31:0] param_rdata,
	output logic param_ack,
	output logic param_err,
	// command outputs
	output logic signed [16:0] speed_target,
	output logic signed [16:0] speed_limit,
	output logic speed_is_limit,
	output logic signed [15:0] current_command,
	output logic [1:0] active_source,
	output logic tuning_auto
);
	function automatic logic signed [39:0] sat(input logic signed [39:0] x,
		input logic signed [39:0] lim);
		if (x > lim) begin
			sat = lim;
		end else if (x < -lim) begin
			sat = -lim;
		end else begin
			sat = x;
		end
	endfunction

	function automatic logic in_rng(input logic signed [31:0] v,
		input logic signed [31:0] lo, input logic signed [31:0] hi);
		in_rng = (v >= lo) && (v <= hi);
	endfunction

	logic [1:0] sel;
	logic [15:0] position_loop_gain;
	logic [15:0] position_feedforward_gain;
	logic signed [16:0] preset_speed [3];
	logic [16:0] analog_speed_scaling;
	scs_pkg::scs_mode_t control_mode_select;
	scs_pkg::scs_tune_t tuning_mode_select;
	logic [15:0] spkp;
	logic [15:0] spki;
	logic [15:0] kpp_eff;
	logic [15:0] ff_eff;
	logic [15:0] spkp_eff;
	logic [15:0] spki_eff;
	logic signed [39:0] integ;
	logic [15:0] next_kpp;
	logic [15:0] next_ff;
	logic signed [16:0] next_preset [3];
	logic [16:0] next_ascale;
	scs_pkg::scs_mode_t next_mode;
	scs_pkg::scs_tune_t next_tune;
	logic [15:0] next_spkp;
	logic [15:0] next_spki;
	logic [31:0] next_rdata;
	logic next_ack;
	logic next_err;
	logic [15:0] next_kpp_eff;
	logic [15:0] next_ff_eff;
	logic [15:0] next_spkp_eff;
	logic [15:0] next_spki_eff;
	logic signed [16:0] next_target;
	logic signed [16:0] next_limit;
	logic next_is_limit;
	logic signed [39:0] next_integ;
	logic signed [15:0] next_current;
	logic signed [39:0] analog_spd;
	logic signed [39:0] pos_spd;
	logic signed [39:0] spd_err;
	logic signed [16:0] sel_cmd;
	logic signed [31:0] wval;
	logic zero_an;
	logic torque;

	scs_sel_sync u_sync (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.pin({speed_select_bit1, speed_select_bit0}),
		.sel(sel)
	);

	// ==========================================
	// parameter access
	always_comb begin
		wval = $signed(param_wdata);
		next_kpp = position_loop_gain;
		next_ff = position_feedforward_gain;
		next_preset = preset_speed;
		next_ascale = analog_speed_scaling;
		next_mode = control_mode_select;
		next_tune = tuning_mode_select;
		next_spkp = spkp;
		next_spki = spki;
		next_rdata = param_rdata;
		next_ack = param_wr | param_rd;
		next_err = 1'b0;
		if (param_wr) begin
			unique case (param_addr)
				scs_pkg::ADDR_KPP: begin
					if (param_wdata <= 32'(scs_pkg::KPP_MAX)) next_kpp = param_wdata[15:0];
					else next_err = 1'b1;
				end
				scs_pkg::ADDR_FF: begin
					if (param_wdata <= 32'(scs_pkg::FF_MAX)) next_ff = param_wdata[15:0];
					else next_err = 1'b1;
				end
				scs_pkg::ADDR_PRESET1, scs_pkg::ADDR_PRESET2, scs_pkg::ADDR_PRESET3: begin
					if (in_rng(wval, scs_pkg::SPD_MIN, scs_pkg::SPD_MAX)) begin
						next_preset[param_addr[3:2] - 2'h0] = wval[16:0];
					end else begin
						next_err = 1'b1;
					end
				end
				scs_pkg::ADDR_ASCALE: begin
					if (param_wdata <= 32'(scs_pkg::ASCALE_MAX)) next_ascale = param_wdata[16:0];
					else next_err = 1'b1;
				end
				scs_pkg::ADDR_MODE: begin
					if (param_wdata <= 32'h00000004) next_mode = scs_pkg::scs_mode_t'(param_wdata[2:0]);
					else next_err = 1'b1;
				end
				scs_pkg::ADDR_TUNE: begin
					if (param_wdata <= 32'h00000001) next_tune = scs_pkg::scs_tune_t'(param_wdata[0]);
					else next_err = 1'b1;
				end
				scs_pkg::ADDR_SPKP: begin
					if (param_wdata[31:16] == 16'h0000) next_spkp = param_wdata[15:0];
					else next_err = 1'b1;
				end
				scs_pkg::ADDR_SPKI: begin
					if (param_wdata[31:16] == 16'h0000) next_spki = param_wdata[15:0];
					else next_err = 1'b1;
				end
				default: next_err = 1'b1;
			endcase
		end else if (param_rd) begin
			unique case (param_addr)
				scs_pkg::ADDR_KPP: next_rdata = {16'h0000, position_loop_gain};
				scs_pkg::ADDR_FF: next_rdata = {16'h0000, position_feedforward_gain};
				scs_pkg::ADDR_PRESET1: next_rdata = 32'(preset_speed[0]);
				scs_pkg::ADDR_PRESET2: next_rdata = 32'(preset_speed[1]);
				scs_pkg::ADDR_PRESET3: next_rdata = 32'(preset_speed[2]);
				scs_pkg::ADDR_ASCALE: next_rdata = {15'h0000, analog_speed_scaling};
				scs_pkg::ADDR_MODE: next_rdata = {29'h00000000, control_mode_select};
				scs_pkg::ADDR_TUNE: next_rdata = {31'h00000000, tuning_mode_select};
				scs_pkg::ADDR_SPKP: next_rdata = {16'h0000, spkp};
				scs_pkg::ADDR_SPKI: next_rdata = {16'h0000, spki};
				default: begin
					next_rdata = 32'h00000000;
					next_err = 1'b1;
				end
			endcase
		end
	end

	// ==========================================
	// effective gains: user values, or tuner values seeded from them
	always_comb begin
		next_kpp_eff = position_loop_gain;
		next_ff_eff = position_feedforward_gain;
		next_spkp_eff = spkp;
		next_spki_eff = spki;
		if (tuning_mode_select == scs_pkg::TUNE_AUTO) begin
			// hold the running set; seeding happens on entry to auto
			next_kpp_eff = kpp_eff;
			next_ff_eff = ff_eff;
			next_spkp_eff = spkp_eff;
			next_spki_eff = spki_eff;
			if (auto_gain_valid) begin
				next_kpp_eff = (auto_kpp > scs_pkg::KPP_MAX) ? scs_pkg::KPP_MAX : auto_kpp;
				next_ff_eff = (auto_ff > scs_pkg::FF_MAX) ? scs_pkg::FF_MAX : auto_ff;
				next_spkp_eff = auto_spkp;
				next_spki_eff = auto_spki;
			end
		end
	end

	// ==========================================
	// command selection and loops
	always_comb begin
		zero_an = (control_mode_select == scs_pkg::MODE_SZ) ||
			(control_mode_select == scs_pkg::MODE_TZ);
		torque = (control_mode_select == scs_pkg::MODE_T) || zero_an &&
			(control_mode_select == scs_pkg::MODE_TZ);
		analog_spd = sat((40'(analog_ref) * $signed({23'h000000, analog_speed_scaling}))
			>>> scs_pkg::ASCALE_SHIFT, scs_pkg::SPD_LIM);
		// feed-forward divides by 100 through a reciprocal, about 0.05 % low
		pos_spd = sat(((40'(pos_error) * $signed({24'h000000, kpp_eff})) >>> scs_pkg::KP_SHIFT)
			+ ((40'(pos_rate) * $signed({24'h000000, ff_eff}) * $signed({24'h000000,
			scs_pkg::FF_RECIP})) >>> scs_pkg::FF_SHIFT), scs_pkg::SPD_LIM);
		unique case (sel)
			scs_pkg::SEL_ANALOG: sel_cmd = zero_an ? 17'sh00000 : analog_spd[16:0];
			scs_pkg::SEL_P1: sel_cmd = preset_speed[0];
			scs_pkg::SEL_P2: sel_cmd = preset_speed[1];
			scs_pkg::SEL_P3: sel_cmd = preset_speed[2];
		endcase
		next_limit = torque ? sel_cmd : 17'sh00000;
		next_is_limit = torque;
		if (torque) begin
			next_target = 17'sh00000;
		end else if (control_mode_select == scs_pkg::MODE_PT) begin
			next_target = pos_spd[16:0];
		end else begin
			next_target = sel_cmd;
		end
		spd_err = 40'(speed_target) - 40'(speed_fb);
		// torque modes park the integrator so no windup carries over
		next_integ = torque ? 40'sh0000000000 :
			sat(integ + spd_err * $signed({24'h000000, spki_eff}), scs_pkg::INT_LIM);
		next_current = torque ? 16'sh0000 : 16'(sat((spd_err * $signed({24'h000000,
			spkp_eff}) + integ) >>> scs_pkg::CUR_SHIFT, scs_pkg::CUR_LIM));
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			position_loop_gain <= scs_pkg::KPP_RST;
			position_feedforward_gain <= scs_pkg::FF_RST;
			preset_speed <= '{3{17'sh00000}};
			analog_speed_scaling <= scs_pkg::ASCALE_RST;
			control_mode_select <= scs_pkg::MODE_PT;
			tuning_mode_select <= scs_pkg::TUNE_MANUAL;
			spkp <= scs_pkg::SPKP_RST;
			spki <= scs_pkg::SPKI_RST;
			param_rdata <= 32'h00000000;
			param_ack <= 1'b0;
			param_err <= 1'b0;
			kpp_eff <= scs_pkg::KPP_RST;
			ff_eff <= scs_pkg::FF_RST;
			spkp_eff <= scs_pkg::SPKP_RST;
			spki_eff <= scs_pkg::SPKI_RST;
			speed_target <= 17'sh00000;
			speed_limit <= 17'sh00000;
			speed_is_limit <= 1'b0;
			integ <= 40'sh0000000000;
			current_command <= 16'sh0000;
			active_source <= 2'h0;
			tuning_auto <= 1'b0;
		end else begin
			position_loop_gain <= next_kpp;
			position_feedforward_gain <= next_ff;
			preset_speed <= next_preset;
			analog_speed_scaling <= next_ascale;
			control_mode_select <= next_mode;
			tuning_mode_select <= next_tune;
			spkp <= next_spkp;
			spki <= next_spki;
			param_rdata <= next_rdata;
			param_ack <= next_ack;
			param_err <= next_err;
			kpp_eff <= next_kpp_eff;
			ff_eff <= next_ff_eff;
			spkp_eff <= next_spkp_eff;
			spki_eff <= next_spki_eff;
			speed_target <= next_target;
			speed_limit <= next_limit;
			speed_is_limit <= next_is_limit;
			integ <= next_integ;
			current_command <= next_current;
			active_source <= sel;
			tuning_auto <= (tuning_mode_select == scs_pkg::TUNE_AUTO);
		end
	end

	// ==========================================
	// checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	kpp_range_a: assert property (kpp_eff <= scs_pkg::KPP_MAX)
		else $error("kpp above range");
	ff_range_a: assert property (position_feedforward_gain <= scs_pkg::FF_MAX)
		else $error("feed-forward above range");
	gain_reset_a: assert property ($rose(rstn) |-> position_loop_gain == 16'h0023 &&
		position_feedforward_gain == 16'h0032)
		else $error("gain reset values wrong");
	zero_analog_a: assert property (sel == 2'h0 && control_mode_select == scs_pkg::MODE_SZ
		|=> speed_target == 17'sh00000)
		else $error("zero-analog command not zero");
	analog_path_a: assert property (sel == 2'h0 && control_mode_select == scs_pkg::MODE_S
		|=> speed_target == $past(analog_spd[16:0]))
		else $error("analog command not taken");
	preset_pick_a: assert property (sel != 2'h0 && control_mode_select == scs_pkg::MODE_S
		|=> speed_target == $past(preset_speed[sel - 2'h1]))
		else $error("wrong preset selected");
	sel_follow_a: assert property ($changed(sel) |=> active_source == $past(sel))
		else $error("select change not applied");
	pin_settle_a: assert property ($changed(sel) |-> $past(u_sync.s3) == $past(u_sync.s2))
		else $error("select switched on unsettled pair");
	preset_reject_a: assert property (param_wr && param_addr == scs_pkg::ADDR_PRESET3 &&
		!in_rng($signed(param_wdata), scs_pkg::SPD_MIN, scs_pkg::SPD_MAX)
		|=> param_err && $stable(preset_speed[2]))
		else $error("out-of-range preset accepted");
	torque_limit_a: assert property (control_mode_select == scs_pkg::MODE_T
		|=> speed_is_limit && speed_target == 17'sh00000)
		else $error("torque mode not limiting");
	manual_gain_a: assert property (tuning_mode_select == scs_pkg::TUNE_MANUAL
		|=> kpp_eff == $past(position_loop_gain) && spkp_eff == $past(spkp))
		else $error("manual mode gains altered");
	auto_hold_a: assert property (tuning_mode_select == scs_pkg::TUNE_AUTO && !auto_gain_valid
		&& $past(tuning_mode_select) == scs_pkg::TUNE_AUTO |=> $stable(kpp_eff))
		else $error("auto gains drifted");

	preset_use_c: cover property (sel == 2'h3 && control_mode_select == scs_pkg::MODE_S);
	sz_zero_c: cover property (sel == 2'h0 && control_mode_select == scs_pkg::MODE_SZ);
	auto_upd_c: cover property (tuning_mode_select == scs_pkg::TUNE_AUTO && auto_gain_valid);
	reject_c: cover property (param_err);
endmodule // scs_speed_cmd

// ==== rtl/scs_pkg.sv ====
// What this block does
// - hold position proportional gain 0..2047 rad/s, reset value 35
// - hold feed-forward gain 0..100 percent, reset 50, applied in pulse-position mode
// - position loop output becomes the speed loop command
// - select 00 in plain speed mode takes the scaled analog reference
// - select 00 in zero-analog mode forces the speed command to zero
// - select 01, 10, 11 pick presets one, two, three
// - a new preset command applies on select change, no trigger needed
// - presets hold -50000..50000 in 0.1 r/min, out-of-range writes rejected
// - analog reference scaled by the full-scale speed setting
// - torque modes use the selected command as a speed limit
// - manual tuning uses only user gains, no automatic adjustment
// - auto tuning adjusts gains itself, seeded from user gains
// - speed loop PI controller makes the current command
package scs_pkg;
	// ==========================================
	// parameter addresses
	localparam logic [15:0] ADDR_KPP = 16'h0200;
	localparam logic [15:0] ADDR_FF = 16'h0204;
	localparam logic [15:0] ADDR_PRESET1 = 16'h0110;
	localparam logic [15:0] ADDR_PRESET2 = 16'h0114;
	localparam logic [15:0] ADDR_PRESET3 = 16'h0118;
	localparam logic [15:0] ADDR_ASCALE = 16'h011C;
	localparam logic [15:0] ADDR_MODE = 16'h0120;
	localparam logic [15:0] ADDR_TUNE = 16'h0124;
	localparam logic [15:0] ADDR_SPKP = 16'h0128;
	localparam logic [15:0] ADDR_SPKI = 16'h012C;
	// ==========================================
	// reset values and ranges
	localparam logic [15:0] KPP_RST = 16'h0023;
	localparam logic [15:0] KPP_MAX = 16'h07FF;
	localparam logic [15:0] FF_RST = 16'h0032;
	localparam logic [15:0] FF_MAX = 16'h0064;
	localparam logic [16:0] ASCALE_RST = 17'h07530;
	localparam logic [16:0] ASCALE_MAX = 17'h0C350;
	localparam logic [15:0] SPKP_RST = 16'h0064;
	localparam logic [15:0] SPKI_RST = 16'h000A;
	localparam logic signed [31:0] SPD_MIN = -32'sh0000C350;
	localparam logic signed [31:0] SPD_MAX = 32'sh0000C350;
	localparam logic signed [39:0] SPD_LIM = 40'sh000000C350;
	localparam logic signed [39:0] CUR_LIM = 40'sh0000007FFF;
	localparam logic signed [39:0] INT_LIM = 40'sh00007FFF00;
	// ==========================================
	// arithmetic scaling
	localparam int ASCALE_SHIFT = 15;
	localparam int KP_SHIFT = 4;
	localparam int FF_SHIFT = 16;
	localparam int CUR_SHIFT = 8;
	localparam logic [15:0] FF_RECIP = 16'h028F;
	// ==========================================
	// select codes and modes
	localparam logic [1:0] SEL_ANALOG = 2'h0;
	localparam logic [1:0] SEL_P1 = 2'h1;
	localparam logic [1:0] SEL_P2 = 2'h2;
	localparam logic [1:0] SEL_P3 = 2'h3;
	typedef enum logic [2:0] {
		MODE_PT = 3'b000,
		MODE_S = 3'b001,
		MODE_SZ = 3'b010,
		MODE_T = 3'b011,
		MODE_TZ = 3'b100
	} scs_mode_t;
	typedef enum logic [0:0] {
		TUNE_MANUAL = 1'b0,
		TUNE_AUTO = 1'b1
	} scs_tune_t;
endpackage

// ==== rtl/scs_sel_sync.sv ====
`timescale 1ns/100ps
module scs_sel_sync (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// raw pins
	input wire logic [1:0] pin,
	// settled pair
	output logic [1:0] sel
);
	logic [1:0] s1;
	logic [1:0] s2;
	logic [1:0] s3;
	logic [1:0] next_sel;

	// ==========================================
	// three stages, accept only a settled pair
	always_comb begin
		next_sel = sel;
		if (s2 == s3) begin
			next_sel = s3;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			s1 <= 2'h0;
			s2 <= 2'h0;
			s3 <= 2'h0;
			sel <= 2'h0;
		end else begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
			sel <= next_sel;
		end
	end
endmodule // scs_sel_sync

// ==== sim/scs_host_model.sv ====
`timescale 1ns/100ps
// ==========================================
// host controller driving the select pins
module scs_host_model (
	// clock
	input wire logic clk_sys,
	// code requested by the bench
	input wire logic [1:0] code,
	// select pins
	output logic speed_select_bit0,
	output logic speed_select_bit1
);
	logic lag1;
	initial begin
		speed_select_bit0 = 1'b0;
		speed_select_bit1 = 1'b0;
		lag1 = 1'b0;
	end
	// bit1 lags bit0 by a cycle: real hosts never switch both pins together
	always @(posedge clk_sys) begin
		speed_select_bit0 <= #1 code[0];
		lag1 <= #1 code[1];
		speed_select_bit1 <= #1 lag1;
	end
endmodule // scs_host_model

// ==== sim/speed_command_select_and_position_gain_tb.sv ====
`timescale 1ns/100ps
module speed_command_select_and_position_gain_tb;
	logic clk_sys, rstn, bit0, bit1, auto_gain_valid, param_wr, param_rd;
	logic param_ack, param_err, speed_is_limit, tuning_auto, err_seen;
	logic [1:0] code, active_source;
	logic signed [15:0] analog_ref, pos_error, pos_rate, current_command;
	logic signed [16:0] speed_fb, speed_target, speed_limit;
	logic [15:0] auto_kpp, param_addr;
	logic [31:0] param_wdata, param_rdata, rd_val;
	logic signed [16:0] preset_exp [1:3];
	int fails, total_checks, i;
	scs_host_model i_host (.clk_sys(clk_sys), .code(code), .speed_select_bit0(bit0),
		.speed_select_bit1(bit1));
	scs_speed_cmd i_dut (.clk_sys(clk_sys), .rstn(rstn), .speed_select_bit0(bit0),
		.speed_select_bit1(bit1), .analog_ref(analog_ref), .pos_error(pos_error),
		.pos_rate(pos_rate), .speed_fb(speed_fb), .auto_gain_valid(auto_gain_valid),
		.auto_kpp(auto_kpp), .auto_ff(16'h0000), .auto_spkp(16'h0000),
		.auto_spki(16'h0000), .param_wr(param_wr), .param_rd(param_rd),
		.param_addr(param_addr), .param_wdata(param_wdata), .param_rdata(param_rdata),
		.param_ack(param_ack), .param_err(param_err), .speed_target(speed_target),
		.speed_limit(speed_limit), .speed_is_limit(speed_is_limit),
		.current_command(current_command), .active_source(active_source),
		.tuning_auto(tuning_auto));
	// ==========================================
	// checks and access tasks
	task automatic stop_test();
		$display("checks %0d errors %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error %s expected %0h seen %0h", name, exp, got);
		end
	endtask
	task automatic chk_spd(input string name, input logic signed [16:0] exp,
		input logic signed [16:0] got);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("Error %s expected %0d seen %0d", name, exp, got);
		end
	endtask
	task automatic access(input logic wr, input logic [15:0] addr, input logic [31:0] data,
		input logic exp_err);
		int n;
		@(posedge clk_sys);
		#1;
		param_wr = wr;
		param_rd = ~wr;
		param_addr = addr;
		param_wdata = data;
		@(posedge clk_sys);
		#1;
		param_wr = 1'b0;
		param_rd = 1'b0;
		for (n = 0; n < 4 && param_ack !== 1'b1; n++) begin
			@(posedge clk_sys);
			#1;
		end
		chk_word("param_ack", 32'h1, {31'h0, param_ack});
		if (param_ack !== 1'b1) begin
			stop_test();
		end
		rd_val = param_rdata;
		chk_word("param_err", {31'h0, exp_err}, {31'h0, param_err});
	endtask
	task automatic rd(input logic [15:0] addr, input logic [31:0] exp, input logic exp_err);
		access(1'b0, addr, 32'h0, exp_err);
		chk_word("param_rdata", exp, rd_val);
	endtask
	task automatic sel(input logic [1:0] c);
		@(posedge clk_sys);
		#1;
		code = c;
		// pin skew plus the five-cycle settle path
		repeat (9) @(posedge clk_sys);
		#1;
		chk_word("active_source", {30'h0, c}, {30'h0, active_source});
	endtask
	task automatic loop_wait();
		repeat (3) @(posedge clk_sys);
		#1;
	endtask
	// ==========================================
	// clock, watchdog, sequence
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		fails++;
		$display("Error watchdog expected done seen hang");
		stop_test();
	end
	initial begin
		{rstn, code, analog_ref, pos_error, pos_rate, speed_fb} = '0;
		{auto_gain_valid, auto_kpp, param_wr, param_rd, param_addr, param_wdata} = '0;
		fails = 0;
		total_checks = 0;
		repeat (6) @(posedge clk_sys);
		#1;
		rstn = 1'b1;
		rd(scs_pkg::ADDR_KPP, 32'h23, 1'b0);
		rd(scs_pkg::ADDR_FF, 32'h32, 1'b0);
		access(1'b1, scs_pkg::ADDR_KPP, 32'h7FF, 1'b0);
		access(1'b1, scs_pkg::ADDR_KPP, 32'h800, 1'b1);
		rd(scs_pkg::ADDR_KPP, 32'h7FF, 1'b0);
		access(1'b1, scs_pkg::ADDR_FF, 32'h64, 1'b0);
		access(1'b1, scs_pkg::ADDR_FF, 32'h65, 1'b1);
		rd(scs_pkg::ADDR_FF, 32'h64, 1'b0);
		access(1'b1, scs_pkg::ADDR_PRESET1, 32'h0000C350, 1'b0);
		access(1'b1, scs_pkg::ADDR_PRESET2, 32'hFFFF3CB0, 1'b0);
		access(1'b1, scs_pkg::ADDR_PRESET3, 32'h0000C351, 1'b1);
		access(1'b1, scs_pkg::ADDR_PRESET3, 32'hFFFF3CAF, 1'b1);
		access(1'b1, scs_pkg::ADDR_PRESET3, 32'h000003E8, 1'b0);
		rd(scs_pkg::ADDR_PRESET2, 32'hFFFF3CB0, 1'b0);
		rd(16'h0300, 32'h0, 1'b1);
		access(1'b1, scs_pkg::ADDR_MODE, 32'h5, 1'b1);
		access(1'b1, scs_pkg::ADDR_MODE, 32'h1, 1'b0);
		preset_exp[1] = 17'sh0C350;
		preset_exp[2] = -17'sh0C350;
		preset_exp[3] = 17'sh003E8;
		analog_ref = 16'sh4000;
		// 01 then 10 passes through 00 on the pins
		for (i = 1; i < 4; i++) begin
			sel(i[1:0]);
			chk_spd("speed_target", preset_exp[i], speed_target);
		end
		sel(2'h1);
		chk_spd("speed_target", preset_exp[1], speed_target);
		sel(2'h0);
		chk_spd("speed_target", 17'sh03A98, speed_target);
		access(1'b1, scs_pkg::ADDR_ASCALE, 32'h0000C351, 1'b1);
		access(1'b1, scs_pkg::ADDR_ASCALE, 32'h0000C350, 1'b0);
		analog_ref = 16'sh7FFF;
		loop_wait();
		chk_spd("speed_target", (32767 * 50000) >>> 15, speed_target);
		access(1'b1, scs_pkg::ADDR_MODE, 32'h2, 1'b0);
		loop_wait();
		chk_spd("speed_target", 17'sh00000, speed_target);
		access(1'b1, scs_pkg::ADDR_MODE, 32'h3, 1'b0);
		sel(2'h1);
		chk_spd("speed_limit", preset_exp[1], speed_limit);
		chk_spd("speed_target", 17'sh00000, speed_target);
		chk_word("speed_is_limit", 32'h1, {31'h0, speed_is_limit});
		chk_word("current_command", 32'h0, {{16{current_command[15]}}, current_command});
		access(1'b1, scs_pkg::ADDR_MODE, 32'h4, 1'b0);
		sel(2'h0);
		chk_spd("speed_limit", 17'sh00000, speed_limit);
		access(1'b1, scs_pkg::ADDR_KPP, 32'h7D, 1'b0);
		access(1'b1, scs_pkg::ADDR_MODE, 32'h0, 1'b0);
		pos_error = 16'sh0010;
		loop_wait();
		chk_spd("speed_target", 17'sh0007D, speed_target);
		pos_error = 16'sh0000;
		pos_rate = 16'sh0064;
		loop_wait();
		chk_spd("speed_target", (100 * 100 * 655) >>> 16, speed_target);
		pos_error = 16'sh0010;
		pos_rate = 16'sh0000;
		access(1'b1, scs_pkg::ADDR_TUNE, 32'h1, 1'b0);
		@(posedge clk_sys);
		#1;
		chk_word("tuning_auto", 32'h1, {31'h0, tuning_auto});
		auto_kpp = 16'h00FA;
		auto_gain_valid = 1'b1;
		@(posedge clk_sys);
		#1;
		auto_gain_valid = 1'b0;
		loop_wait();
		chk_spd("speed_target", 17'sh000FA, speed_target);
		access(1'b1, scs_pkg::ADDR_TUNE, 32'h0, 1'b0);
		loop_wait();
		chk_word("tuning_auto", 32'h0, {31'h0, tuning_auto});
		chk_spd("speed_target", 17'sh0007D, speed_target);
		stop_test();
	end
endmodule // speed_command_select_and_position_gain_tb
